// [include/can_fifo_ctrl_pkg.sv]
/*
  Constants for the message queue and message FIFO control block: register
  offsets, field positions, reset values and the payload size decode.
  Assumes a 32-bit APB register port with byte addresses in paddr[7:0].
*/
package can_fifo_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_FIFOS = 15;
  localparam int ADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses; message fifo m sits at m words
  localparam logic [7:0] TXQ_STATUS_OFS = 8'h00;
  localparam logic [7:0] GLOBAL_CTRL_OFS = 8'h40;
  localparam logic [5:0] GLOBAL_CTRL_IDX = 6'h10;
  localparam logic [5:0] TXQ_STATUS_IDX = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // message_fifo_control fields
  localparam int PLSZ_LSB = 29;
  localparam int DEPTH_LSB = 24;
  localparam int RETRY_LSB = 21;
  localparam int PRIO_LSB = 16;
  localparam int FIFO_RESET_BIT = 10;
  localparam int SENDREQ_BIT = 9;
  localparam int INC_BIT = 8;
  localparam int DIR_BIT = 7;
  localparam int RTR_BIT = 6;
  localparam int TS_BIT = 5;
  localparam int IE_ATTEMPTS = 4;
  localparam int IE_OVERFLOW = 3;
  localparam int IE_EMPTY_FULL = 2;
  localparam int IE_HALF = 1;
  localparam int IE_NFNE = 0;

  ////////////////////////////////////////////////////////////////////////////
  // transmit_queue_status fields
  localparam int QIDX_LSB = 8;
  localparam int QABT_BIT = 7;
  localparam int QLARB_BIT = 6;
  localparam int QERR_BIT = 5;
  localparam int QATIF_BIT = 4;
  localparam int QEMPTY_BIT = 2;
  localparam int QNFULL_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // global control fields and reset values
  localparam int OPMODE_LSB = 0;
  localparam int RETRY_EN_BIT = 8;
  localparam logic [2:0] OPMODE_CONFIG = 3'h4;
  localparam logic [2:0] OPMODE_RESET = 3'h4;
  localparam logic [1:0] RETRY_RESET = 2'h3;
  localparam logic [1:0] RETRY_OFF = 2'h0;
  localparam logic FIFO_RESET_RESET = 1'b1;
  localparam logic QFLAG_RESET = 1'b1;

  // data bytes carried by one message object
  function automatic logic [6:0] payload_bytes(input logic [2:0] code);
    case (code)
      3'h0: payload_bytes = 7'h08;
      3'h1: payload_bytes = 7'h0C;
      3'h2: payload_bytes = 7'h10;
      3'h3: payload_bytes = 7'h14;
      3'h4: payload_bytes = 7'h18;
      3'h5: payload_bytes = 7'h20;
      3'h6: payload_bytes = 7'h30;
      default: payload_bytes = 7'h40;
    endcase
  endfunction

endpackage

// [hw/can_fifo_ctrl.sv]
/*
  Control and status for the transmit queue and message FIFOs 1 to 15 of a
  CAN FD controller, reached over APB. Assumes the protocol engine runs on
  pclk and gives one-cycle event pulses; the message RAM lives elsewhere.
*/
// The APB register port and the register addresses were left to the implementer.
// Summary of operation
// - queue status bits 12:8 give slot index the queue sends next
// - that index counts from zero and stays below the queue depth
// - status bit 7 set means last message aborted, clear means success
// - status bit 6 set means the message lost arbitration
// - status bit 5 set means a bus error hit the message
// - a status read or queue reset clears those three bits, except in a cycle where a completion lands, which wins
// - those three bits change only on completion, abort, status read or queue reset
// - bit 4 attempts flag set by hardware only, resets 0, software clears
// - bit 2 empty and bit 0 not-full flags track queue, both reset 1
// - payload code selects 8,12,16,20,24,32,48 or 64 data bytes
// - depth field bits 28:24 give field plus one messages, up to 32
// - retry field 00 none, 01 three, else unlimited, needs global enable
// - retry field stays writable outside configuration mode
// - priority field ranks messages, 00000 lowest to 11111 highest
// - payload, depth, direction, timestamp writable only in mode 100
// - fifo reset bit resets fifo, holds in config, self clears otherwise
// - send request sends; hardware clears when drained; software clear aborts
// - increment bit advances head when transmitting, tail when receiving
// - bit 7 picks transmit (1) or receive (0) object
// - with auto reply on, a received remote request sets send request
// - timestamp enable asks for time stamps in received objects
// - enables 4:0 gate attempts, overflow, empty/full, half, not-full/not-empty
`timescale 1ns/10ps
`default_nettype none

module can_fifo_ctrl
  import can_fifo_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [can_fifo_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txq_done,
  input wire logic txq_done_aborted,
  input wire logic txq_done_lost_arb,
  input wire logic txq_done_bus_err,
  input wire logic txq_attempts_out,
  input wire logic txq_reset,
  input wire logic [4:0] txq_index_in,
  input wire logic [4:0] txq_depth_in,
  input wire logic txq_empty_in,
  input wire logic txq_full_in,
  input wire logic [15:1] fifo_msg_sent,
  input wire logic [15:1] fifo_msg_stored,
  input wire logic [15:1] fifo_rtr_rx,
  input wire logic [15:1] fifo_attempts_out,
  output logic [2:0] operating_mode_field,
  output logic [15:1] fifo_send_pending,
  output logic [15:1] fifo_abort_req,
  output logic [15:1] fifo_is_tx,
  output logic [15:1] fifo_ts_en,
  output logic [15:1] fifo_in_reset,
  output logic [15:1] fifo_irq,
  output logic [6:0] fifo_payload_bytes [1:15],
  output logic [4:0] fifo_next_index [1:15],
  output logic [4:0] fifo_priority [1:15],
  output logic [1:0] fifo_retry_mode [1:15]
);
  import can_fifo_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic [5:0] word_idx;
  logic access;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic cfg_mode;
  logic global_retry_enable_q;
  logic [4:0] queue_next_index_q;
  logic msg_aborted_q;
  logic msg_lost_arbitration_q;
  logic msg_bus_error_q;
  logic attempts_exhausted_flag_q;
  logic queue_empty_flag_q;
  logic queue_not_full_flag_q;
  logic [31:0] rd_word;

  logic [2:0] payload_size_q [1:15];
  logic [4:0] fifo_depth_q [1:15];
  logic [1:0] retry_attempts_q [1:15];
  logic [4:0] send_priority_q [1:15];
  logic [15:1] fifo_reset_q;
  logic [15:1] send_request_q;
  logic [15:1] direction_select_q;
  logic [15:1] auto_remote_reply_en_q;
  logic [15:1] rx_timestamp_en_q;
  logic [4:0] ie_q [1:15];
  logic [5:0] count_q [1:15];

  assign word_idx = paddr[7:2];
  assign access = psel & penable;
  assign wr_en = access & pwrite & hit;
  assign rd_en = access & ~pwrite & hit;
  assign cfg_mode = (operating_mode_field == OPMODE_CONFIG);
  // unmapped words and unaligned addresses answer with an error
  assign hit = (paddr[1:0] == 2'h0) && (word_idx <= GLOBAL_CTRL_IDX);
  // every register answers at once, so no wait states
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  ////////////////////////////////////////////////////////////////////////////
  // global control: operating mode and retry enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operating_mode_field <= OPMODE_RESET;
      global_retry_enable_q <= 1'b0;
    end else if (wr_en && word_idx == GLOBAL_CTRL_IDX) begin
      operating_mode_field <= pwdata[OPMODE_LSB +: 3];
      global_retry_enable_q <= pwdata[RETRY_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit queue completion status; a completion beats a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_aborted_q <= 1'b0;
      msg_lost_arbitration_q <= 1'b0;
      msg_bus_error_q <= 1'b0;
    end else if (txq_done) begin
      msg_aborted_q <= txq_done_aborted;
      msg_lost_arbitration_q <= txq_done_lost_arb;
      msg_bus_error_q <= txq_done_bus_err;
    end else if (txq_reset || (rd_en && word_idx == TXQ_STATUS_IDX)) begin
      msg_aborted_q <= 1'b0;
      msg_lost_arbitration_q <= 1'b0;
      msg_bus_error_q <= 1'b0;
    end
  end

  // attempts flag: hardware sets, software writes 0 to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attempts_exhausted_flag_q <= 1'b0;
    end else if (txq_attempts_out) begin
      attempts_exhausted_flag_q <= 1'b1;
    end else if (txq_reset) begin
      attempts_exhausted_flag_q <= 1'b0;
    end else if (wr_en && word_idx == TXQ_STATUS_IDX && !pwdata[QATIF_BIT]) begin
      attempts_exhausted_flag_q <= 1'b0;
    end
  end

  // queue level flags and index; index outside the depth reads as slot 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_empty_flag_q <= QFLAG_RESET;
      queue_not_full_flag_q <= QFLAG_RESET;
      queue_next_index_q <= 5'h00;
    end else begin
      queue_empty_flag_q <= txq_empty_in;
      queue_not_full_flag_q <= ~txq_full_in;
      queue_next_index_q <= (txq_index_in > txq_depth_in) ? 5'h00 : txq_index_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per fifo control and level tracking
  for (genvar m = 1; m <= NUM_FIFOS; m++) begin : g_fifo
    logic wr_hit;
    logic inc_wr;
    logic [5:0] depth_n;
    logic empty;
    logic full;
    logic half;
    logic push;
    logic pop;
    logic overflow_q;
    logic attempts_q;
    logic [4:0] flags;

    assign wr_hit = wr_en && (word_idx == 6'(m));
    assign inc_wr = wr_hit && pwdata[INC_BIT] && !fifo_reset_q[m];
    assign depth_n = {1'b0, fifo_depth_q[m]} + 6'h01;
    assign empty = (count_q[m] == 6'h00);
    assign full = (count_q[m] == depth_n);
    // transmit: at most half full; receive: at least half full
    assign half = direction_select_q[m] ? ({1'b0, count_q[m]} << 1) <= {1'b0, depth_n}
                                        : ({1'b0, count_q[m]} << 1) >= {1'b0, depth_n};
    // software queues at the head on transmit, frees at the tail on receive
    assign push = direction_select_q[m] ? (inc_wr && !full) : (fifo_msg_stored[m] && !full);
    assign pop = direction_select_q[m] ? (fifo_msg_sent[m] && !empty) : (inc_wr && !empty);

    // configuration-only fields; retry, priority, auto reply and interrupt enables stay writable
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        payload_size_q[m] <= 3'h0;
        fifo_depth_q[m] <= 5'h00;
        direction_select_q[m] <= 1'b0;
        rx_timestamp_en_q[m] <= 1'b0;
        retry_attempts_q[m] <= RETRY_RESET;
        send_priority_q[m] <= 5'h00;
        auto_remote_reply_en_q[m] <= 1'b0;
        ie_q[m] <= 5'h00;
      end else if (wr_hit) begin
        if (cfg_mode) begin
          payload_size_q[m] <= pwdata[PLSZ_LSB +: 3];
          fifo_depth_q[m] <= pwdata[DEPTH_LSB +: 5];
          direction_select_q[m] <= pwdata[DIR_BIT];
          rx_timestamp_en_q[m] <= pwdata[TS_BIT];
        end
        retry_attempts_q[m] <= pwdata[RETRY_LSB +: 2];
        send_priority_q[m] <= pwdata[PRIO_LSB +: 5];
        auto_remote_reply_en_q[m] <= pwdata[RTR_BIT];
        ie_q[m] <= pwdata[4:0];
      end
    end

    // fifo reset: held while in configuration mode, self clears otherwise
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fifo_reset_q[m] <= FIFO_RESET_RESET;
      end else if (wr_hit && pwdata[FIFO_RESET_BIT]) begin
        fifo_reset_q[m] <= 1'b1;
      end else if (fifo_reset_q[m] && !cfg_mode) begin
        fifo_reset_q[m] <= 1'b0;
      end
    end

    // send request; a remote request or a set write beats a software or drain clear, fifo reset or receive direction beats both
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        send_request_q[m] <= 1'b0;
        fifo_abort_req[m] <= 1'b0;
      end else begin
        fifo_abort_req[m] <= 1'b0;
        if (!direction_select_q[m] || fifo_reset_q[m]) begin
          send_request_q[m] <= 1'b0;
        end else if (fifo_rtr_rx[m] && auto_remote_reply_en_q[m]) begin
          send_request_q[m] <= 1'b1;
        end else if (wr_hit && pwdata[SENDREQ_BIT]) begin
          send_request_q[m] <= 1'b1;
        end else if (wr_hit && send_request_q[m]) begin
          send_request_q[m] <= 1'b0;
          fifo_abort_req[m] <= 1'b1;
        end else if (pop && count_q[m] == 6'h01) begin
          send_request_q[m] <= 1'b0;
        end
      end
    end

    // message count and next index; index wraps at the depth
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        count_q[m] <= 6'h00;
        fifo_next_index[m] <= 5'h00;
      end else if (fifo_reset_q[m]) begin
        count_q[m] <= 6'h00;
        fifo_next_index[m] <= 5'h00;
      end else begin
        count_q[m] <= count_q[m] + (push ? 6'h01 : 6'h00) - (pop ? 6'h01 : 6'h00);
        if (direction_select_q[m] ? pop : push) begin
          fifo_next_index[m] <= (fifo_next_index[m] >= fifo_depth_q[m]) ? 5'h00
                                : fifo_next_index[m] + 5'h01;
        end
      end
    end

    // sticky flags, cleared only by a fifo reset here
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        overflow_q <= 1'b0;
        attempts_q <= 1'b0;
      end else begin
        if (!direction_select_q[m] && fifo_msg_stored[m] && full) begin
          overflow_q <= 1'b1;
        end else if (fifo_reset_q[m]) begin
          overflow_q <= 1'b0;
        end
        if (direction_select_q[m] && fifo_attempts_out[m]) begin
          attempts_q <= 1'b1;
        end else if (fifo_reset_q[m]) begin
          attempts_q <= 1'b0;
        end
      end
    end

    // flag meaning follows the direction; a transmit fifo never overflows
    assign flags[IE_ATTEMPTS] = attempts_q & direction_select_q[m];
    assign flags[IE_OVERFLOW] = overflow_q & ~direction_select_q[m];
    assign flags[IE_EMPTY_FULL] = direction_select_q[m] ? empty : full;
    assign flags[IE_HALF] = half;
    assign flags[IE_NFNE] = direction_select_q[m] ? ~full : ~empty;

    // registered outputs toward the engine and interrupt collector
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fifo_irq[m] <= 1'b0;
        fifo_payload_bytes[m] <= 7'h08;
        fifo_retry_mode[m] <= RETRY_OFF;
      end else begin
        fifo_irq[m] <= |(flags & ie_q[m]);
        fifo_payload_bytes[m] <= payload_bytes(payload_size_q[m]);
        // without the global enable no retransmission is attempted
        fifo_retry_mode[m] <= global_retry_enable_q ? retry_attempts_q[m] : RETRY_OFF;
      end
    end

    assign fifo_priority[m] = send_priority_q[m];
  end

  assign fifo_send_pending = send_request_q;
  assign fifo_is_tx = direction_select_q;
  assign fifo_ts_en = rx_timestamp_en_q;
  assign fifo_in_reset = fifo_reset_q;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; increment bit always reads 0
  always_comb begin
    rd_word = 32'h0000_0000;
    if (word_idx == TXQ_STATUS_IDX) begin
      rd_word[QIDX_LSB +: 5] = queue_next_index_q;
      rd_word[QABT_BIT] = msg_aborted_q;
      rd_word[QLARB_BIT] = msg_lost_arbitration_q;
      rd_word[QERR_BIT] = msg_bus_error_q;
      rd_word[QATIF_BIT] = attempts_exhausted_flag_q;
      rd_word[QEMPTY_BIT] = queue_empty_flag_q;
      rd_word[QNFULL_BIT] = queue_not_full_flag_q;
    end else if (word_idx == GLOBAL_CTRL_IDX) begin
      rd_word[OPMODE_LSB +: 3] = operating_mode_field;
      rd_word[RETRY_EN_BIT] = global_retry_enable_q;
    end else begin
      for (int i = 1; i <= NUM_FIFOS; i++) begin
        if (word_idx == 6'(i)) begin
          rd_word[PLSZ_LSB +: 3] = payload_size_q[i];
          rd_word[DEPTH_LSB +: 5] = fifo_depth_q[i];
          rd_word[RETRY_LSB +: 2] = retry_attempts_q[i];
          rd_word[PRIO_LSB +: 5] = send_priority_q[i];
          rd_word[FIFO_RESET_BIT] = fifo_reset_q[i];
          rd_word[SENDREQ_BIT] = send_request_q[i];
          rd_word[DIR_BIT] = direction_select_q[i];
          rd_word[RTR_BIT] = auto_remote_reply_en_q[i];
          rd_word[TS_BIT] = rx_timestamp_en_q[i];
          rd_word[4:0] = ie_q[i];
        end
      end
    end
  end

  // read data latched in the setup cycle, so it is stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit ? rd_word : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// [verification/can_fifo_ctrl_props.sv]
/*
  Concurrent checks on the ports of the fifo control block.
  Assumes it is bound to can_fifo_ctrl and sees its ports by name.
*/
`timescale 1ns/10ps
`default_nettype none

module can_fifo_ctrl_props
  import can_fifo_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] operating_mode_field,
  input wire logic [15:1] fifo_send_pending,
  input wire logic [15:1] fifo_abort_req,
  input wire logic [15:1] fifo_is_tx,
  input wire logic [15:1] fifo_ts_en,
  input wire logic [15:1] fifo_in_reset,
  input wire logic [15:1] fifo_msg_sent,
  input wire logic [15:1] fifo_msg_stored,
  input wire logic [15:1] fifo_rtr_rx,
  input wire logic [6:0] fifo_payload_bytes [1:15],
  input wire logic [4:0] fifo_next_index [1:15]
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // any write lands at its access edge, so it excuses register changes
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  sequence s_access;
    psel && penable;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  property p_ready_now;
    s_access |-> pready;
  endproperty
  a_ready_now: assert property (p_ready_now) else $error("access phase without ready");
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
  property p_payload_code;
    fifo_payload_bytes[1] inside {7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
  endproperty
  a_payload_code: assert property (p_payload_code) else $error("odd payload size");
  property p_cfg_lock;
    operating_mode_field != OPMODE_CONFIG
      |=> $stable(fifo_payload_bytes[1]) && $stable(fifo_is_tx[1]) && $stable(fifo_ts_en[1]);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("locked field changed");
  property p_fifo_reset;
    fifo_in_reset[1] && !wr_acc
      |=> fifo_in_reset[1] == ($past(operating_mode_field) == OPMODE_CONFIG);
  endproperty
  a_fifo_reset: assert property (p_fifo_reset) else $error("fifo reset bit wrong");
  property p_abort_src;
    fifo_abort_req[1] |-> $past(fifo_send_pending[1]) && !fifo_send_pending[1];
  endproperty
  a_abort_src: assert property (p_abort_src) else $error("abort without request");
  property p_send_drain;
    $fell(fifo_send_pending[1])
      |-> $past(fifo_msg_sent[1] || wr_acc || fifo_in_reset[1] || !fifo_is_tx[1]);
  endproperty
  a_send_drain: assert property (p_send_drain) else $error("request dropped alone");
  property p_rx_idle;
    !fifo_is_tx[2] && !fifo_send_pending[2] && !fifo_rtr_rx[2] && !wr_acc
      |=> !fifo_send_pending[2];
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("receive fifo requested send");
  property p_index_src;
    $changed(fifo_next_index[2])
      |-> $past(fifo_msg_sent[2] || fifo_msg_stored[2] || fifo_in_reset[2] || wr_acc);
  endproperty
  a_index_src: assert property (p_index_src) else $error("index moved alone");
endmodule

`default_nettype wire

// [verification/can_engine_model.sv]
/*
  Behavioural protocol engine beside the fifo control block: event pulses
  and queue levels. Assumes one bench process calls its tasks.
*/
`timescale 1ns/10ps
`default_nettype none

module can_engine_model (
  input wire logic pclk,
  output logic txq_done,
  output logic txq_done_aborted,
  output logic txq_done_lost_arb,
  output logic txq_done_bus_err,
  output logic txq_attempts_out,
  output logic txq_reset,
  output logic [4:0] txq_index_in,
  output logic [4:0] txq_depth_in,
  output logic txq_empty_in,
  output logic txq_full_in,
  output logic [15:1] fifo_msg_sent,
  output logic [15:1] fifo_msg_stored,
  output logic [15:1] fifo_rtr_rx,
  output logic [15:1] fifo_attempts_out
);
  // quiet bus, empty queue
  initial begin
    {txq_done, txq_attempts_out, txq_reset} = 3'h0;
    {txq_done_aborted, txq_done_lost_arb, txq_done_bus_err} = 3'h0;
    {txq_index_in, txq_depth_in, txq_empty_in, txq_full_in} = 12'h002;
    {fifo_msg_sent, fifo_msg_stored, fifo_rtr_rx, fifo_attempts_out} = 60'h0;
  end

  // one finished message; qualifiers flip after so stale ones never look valid
  task automatic finish(input logic [2:0] q);
    @(posedge pclk);
    txq_done <= 1'b1;
    {txq_done_aborted, txq_done_lost_arb, txq_done_bus_err} <= q;
    @(posedge pclk);
    txq_done <= 1'b0;
    {txq_done_aborted, txq_done_lost_arb, txq_done_bus_err} <= ~q;
  endtask

  // kinds: 0 sent, 1 stored, 2 remote request, 3 attempts, 4 queue attempts, else queue reset
  task automatic pulse(input int k, input int m);
    logic [15:1] v;
    v = 15'h0;
    if (m > 0) v[m] = 1'b1;
    @(posedge pclk);
    case (k)
      0: fifo_msg_sent <= v;
      1: fifo_msg_stored <= v;
      2: fifo_rtr_rx <= v;
      3: fifo_attempts_out <= v;
      4: txq_attempts_out <= 1'b1;
      default: txq_reset <= 1'b1;
    endcase
    @(posedge pclk);
    {fifo_msg_sent, fifo_msg_stored, fifo_rtr_rx, fifo_attempts_out} <= 60'h0;
    {txq_attempts_out, txq_reset} <= 2'h0;
  endtask

  // queue slot, depth and fill levels
  task automatic level(input logic [4:0] idx, input logic [4:0] dep, input logic emp,
                       input logic ful);
    @(posedge pclk);
    {txq_index_in, txq_depth_in, txq_empty_in, txq_full_in} <= {idx, dep, emp, ful};
  endtask
endmodule

`default_nettype wire

// [verification/can_fd_message_fifo_control_tb.sv]
/*
  Self-checking bench for the fifo control block: APB master, engine model,
  random status events. Assumes the package and checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module can_fd_message_fifo_control_tb;
  import can_fifo_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, c1, w;
  logic txq_done, txq_done_aborted, txq_done_lost_arb, txq_done_bus_err;
  logic txq_attempts_out, txq_reset, txq_empty_in, txq_full_in;
  logic [4:0] txq_index_in, txq_depth_in;
  logic [15:1] fifo_msg_sent, fifo_msg_stored, fifo_rtr_rx, fifo_attempts_out;
  logic [2:0] operating_mode_field;
  logic [15:1] fifo_send_pending, fifo_abort_req, fifo_is_tx, fifo_ts_en, fifo_in_reset, fifo_irq;
  logic [6:0] fifo_payload_bytes [1:15];
  logic [4:0] fifo_next_index [1:15];
  logic [4:0] fifo_priority [1:15];
  logic [1:0] fifo_retry_mode [1:15];
  int n_mismatch, comparisons, n_abort;

  can_fifo_ctrl dut_u (.*);
  can_engine_model eng_u (.*);

  always #10 pclk = ~pclk;
  // abort pulses last one cycle, so count them as they pass
  always @(posedge pclk) if (fifo_abort_req[1] === 1'b1) n_abort <= n_abort + 1;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [6:0] pbytes(input logic [2:0] c);
    logic [6:0] t [0:7];
    t = '{7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
    return t[c];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one transfer; an idle cycle always precedes the setup
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, psel, penable, pwrite, paddr, pwdata, presetn} = 45'h0;
    {n_mismatch, comparisons, n_abort, seed} = {32'h0, 32'h0, 32'h0, 32'd95};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, TXQ_STATUS_OFS, 32'h0);
    chk(rd, 32'h0000_0005);
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0060_0400);
    apb(1'b0, 8'h44, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      eng_u.level(i[4:0], 5'h03, i == 0, i == 3);
      apb(1'b0, TXQ_STATUS_OFS, 32'h0);
      chk(rd, {19'h0, i[4:0], 5'h0, i == 0, 1'b0, i != 3});
    end
    eng_u.level(5'h0, 5'h03, 1'b1, 1'b0);
    repeat (8) begin
      w = xs();
      eng_u.finish(w[2:0]);
      apb(1'b0, TXQ_STATUS_OFS, 32'h0);
      chk(rd, {24'h0, w[2:0], 5'h05});
      apb(1'b0, TXQ_STATUS_OFS, 32'h0);
      chk(rd, 32'h5);
    end
    eng_u.finish(3'h7);
    eng_u.pulse(5, 0);
    apb(1'b0, TXQ_STATUS_OFS, 32'h0);
    chk(rd, 32'h5);
    eng_u.pulse(4, 0);
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, TXQ_STATUS_OFS, (j == 0) ? 32'h10 : 32'h0);
      apb(1'b0, TXQ_STATUS_OFS, 32'h0);
      chk(rd, (j == 0) ? 32'h15 : 32'h5);
    end
    $display("test queue status done");
    for (int k = 0; k < 8; k++) begin
      w = xs();
      w = {k[2:0], 5'h03, 1'b0, 2'h3, (k == 0) ? 5'h1F : (k == 1) ? 5'h00 : w[4:0],
           8'h00, 1'b1, 1'b0, k[0], 5'h1F};
      apb(1'b1, 8'(4 * (k + 1)), w);
      apb(1'b0, 8'(4 * (k + 1)), 32'h0);
      chk(rd, w | 32'h400);
      chk(32'(fifo_payload_bytes[k + 1]), 32'(pbytes(k[2:0])));
      chk(32'(fifo_priority[k + 1]), 32'(w[20:16]));
      chk({fifo_ts_en[k + 1], fifo_is_tx[k + 1]}, {k[0], 1'b1});
    end
    apb(1'b1, 8'h08, 32'h0300_0001);
    c1 = 32'h037F_0080;
    apb(1'b1, GLOBAL_CTRL_OFS, 32'h100);
    apb(1'b1, 8'h04, 32'hFF20_0020);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0320_0080);
    chk({25'(fifo_payload_bytes[1]), fifo_ts_en[1], fifo_retry_mode[1]}, 32'h41);
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 8'h04, c1 & 32'hFF9F_FFFF | (32'(r) << 21));
      repeat (2) @(negedge pclk);
      chk(32'(fifo_retry_mode[1]), r);
    end
    apb(1'b1, GLOBAL_CTRL_OFS, 32'h0);
    repeat (2) @(negedge pclk);
    chk(32'(fifo_retry_mode[1]), 32'h0);
    apb(1'b1, GLOBAL_CTRL_OFS, 32'h100);
    apb(1'b1, 8'h04, c1 | 32'h400);
    for (int t = 0; t < 8; t++) begin
      apb(1'b0, 8'h04, 32'h0);
      if (rd[10] === 1'b0) break;
    end
    chk(32'(rd[10]), 32'h0);
    $display("test configuration done");
    apb(1'b1, 8'h04, c1 | 32'h100);
    apb(1'b1, 8'h04, c1 | 32'h100);
    apb(1'b1, 8'h04, c1 | 32'h200);
    for (int s = 1; s < 3; s++) begin
      eng_u.pulse(0, 1);
      @(negedge pclk);
      chk({fifo_next_index[1], 26'h0, fifo_send_pending[1]}, {s[4:0], 26'h0, s == 1});
    end
    apb(1'b1, 8'h04, c1 | 32'h340);
    apb(1'b1, 8'h04, c1 | 32'h040);
    eng_u.pulse(2, 1);
    @(negedge pclk);
    chk(32'(fifo_send_pending[1]), 32'h1);
    apb(1'b1, 8'h04, c1);
    eng_u.pulse(2, 1);
    @(negedge pclk);
    chk({fifo_send_pending[1], 31'(n_abort)}, 32'h2);
    $display("test send request done");
    apb(1'b1, 8'h08, 32'h0300_0201);
    eng_u.pulse(1, 2);
    repeat (2) @(negedge pclk);
    chk({fifo_next_index[2], fifo_send_pending[2], fifo_irq[2]}, 7'h05);
    apb(1'b1, 8'h08, 32'h0300_0101);
    repeat (2) @(negedge pclk);
    chk(32'(fifo_irq[2]), 32'h0);
    apb(1'b1, 8'h08, 32'h0300_0000);
    eng_u.pulse(1, 2);
    repeat (2) @(negedge pclk);
    chk({fifo_next_index[2], fifo_irq[2]}, 6'h4);
    $display("test receive fifo done");
    stop_test();
  end
endmodule

bind can_fifo_ctrl can_fifo_ctrl_props chk_u (.*);

`default_nettype wire
